//--- converter_status_pkg.sv
// Register map, field positions and reset values for the converter status block.
package converter_status_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FLAG_W = 4;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CONVERTER3_STATUS = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 8'h21;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h22;

    // ------------------------------------------------------------------
    // Field positions of converter3_status
    // ------------------------------------------------------------------
    localparam int BIT_FAULT_FLAG = 7;
    localparam int BIT_RETRY_FLAG = 6;
    localparam int BIT_NEG_LIMIT_FLAG = 5;
    localparam int BIT_ZERO_CROSS_FLAG = 4;
    localparam int BIT_RESERVED = 3;
    localparam int BIT_SOFTSTART_DONE = 2;
    localparam int BIT_POWER_GOOD = 1;
    localparam int BIT_ENABLED_STATUS = 0;

    // Index of each latched flag within the four-bit flag vector.
    localparam int FLAG_ZERO_CROSS = 0;
    localparam int FLAG_NEG_LIMIT = 1;
    localparam int FLAG_RETRY = 2;
    localparam int FLAG_FAULT = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
    localparam logic [FLAG_W-1:0] IRQ_ENABLE_RESET = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;
    localparam logic RESERVED_VALUE = 1'b0;

endpackage : converter_status_pkg

//--- sticky_flags.sv
// Bank of sticky flags where a set in the same cycle as a clear wins.
`timescale 1ns/1ps
`default_nettype none

module sticky_flags
    import converter_status_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [FLAG_W-1:0] set, // One-cycle set per flag.
    input wire logic [FLAG_W-1:0] clear, // One-cycle clear per flag.
    output logic [FLAG_W-1:0] flags // Held flag values.
);

    // ------------------------------------------------------------------
    // Per-bit latches
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < FLAG_W; i++) begin : g_flag
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    flags[i] <= FLAGS_RESET[i];
                end else if (set[i]) begin
                    flags[i] <= 1'b1;
                end else if (clear[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : sticky_flags

`default_nettype wire

//--- converter_status_register.sv
// Status register of the third converter channel with its event interrupt.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module converter_status_register
    import converter_status_pkg::*;
(
    input wire logic core_clk, // System clock, 50 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [ADDR_W-1:0] reg_addr, // Register address.
    input wire logic [DATA_W-1:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    output logic [DATA_W-1:0] reg_rdata, // Read data, valid the cycle after reg_rd.
    input wire logic conv_enabled, // Converter is enabled.
    input wire logic ramp_finished, // Soft-start ramp has completed.
    input wire logic power_good_cmp, // Power-good comparator output.
    input wire logic oc_terminal_count, // Overcurrent counter reached terminal count.
    input wire logic negative_limit_event, // Negative current limit reached.
    input wire logic zero_cross_event, // Zero-cross comparator tripped.
    output logic irq // Level interrupt, high while an enabled event is pending.
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic rd_status;
    logic rd_irq_status;
    logic rd_irq_enable;
    logic wr_irq_clear;
    logic wr_irq_enable;

    // Each offset selects one register only. The status and interrupt status
    // arms ignore the write strobe: both registers are read-only, and a stray
    // write must never disturb an event that is still pending.
    always_comb begin
        rd_status = 1'b0;
        rd_irq_status = 1'b0;
        rd_irq_enable = 1'b0;
        wr_irq_clear = 1'b0;
        wr_irq_enable = 1'b0;
        case (reg_addr)
            ADDR_CONVERTER3_STATUS: begin
                rd_status = reg_rd;
            end
            ADDR_IRQ_STATUS: begin
                rd_irq_status = reg_rd;
            end
            ADDR_IRQ_CLEAR: begin
                wr_irq_clear = reg_wr;
            end
            ADDR_IRQ_ENABLE: begin
                rd_irq_enable = reg_rd;
                wr_irq_enable = reg_wr;
            end
            default: begin
                // Unmapped offsets read as zero and take no writes.
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Live status bits
    // ------------------------------------------------------------------
    logic softstart_done;
    logic power_good;
    logic enabled_status;

    // These bits are not latched: a read shows the inputs as they stand in the
    // read cycle, so a dip that comes and goes between two reads is never seen.
    assign softstart_done = conv_enabled && ramp_finished;
    assign power_good = power_good_cmp;
    assign enabled_status = conv_enabled;

    // ------------------------------------------------------------------
    // Latched flags
    // ------------------------------------------------------------------
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_clear;
    logic retry_set;
    logic fault_condition;

    // Only the counter event while power is not good arms the retry flag.
    // The retry mode setting that decides what follows lives outside this block.
    assign retry_set = oc_terminal_count && !power_good;

    // A regulator that is up and ramped but out of regulation is a fault.
    assign fault_condition = enabled_status && softstart_done && !power_good;

    // The fault also follows the retry event itself, so it never lags it by a cycle.
    always_comb begin
        flag_set = FLAGS_RESET;
        flag_set[FLAG_FAULT] = retry_set || flags[FLAG_RETRY] || fault_condition;
        flag_set[FLAG_RETRY] = retry_set;
        flag_set[FLAG_NEG_LIMIT] = negative_limit_event;
        flag_set[FLAG_ZERO_CROSS] = zero_cross_event;
    end

    // A read clears every flag it returned; a set in that cycle still wins.
    // Hence a read while the retry flag is up clears retry, but the fault
    // relatches from it at the same edge and shows once more on the next read.
    // A fault condition that persists keeps the fault flag up across reads.
    assign flag_clear = {FLAG_W{rd_status}};

    // Each flag is its own flop, so one source never masks another.
    sticky_flags u_status_flags (
        .core_clk (core_clk),
        .rst (rst),
        .set (flag_set),
        .clear (flag_clear),
        .flags (flags)
    );

    // ------------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------------
    logic [FLAG_W-1:0] irq_status;
    logic [FLAG_W-1:0] irq_enable;
    logic [FLAG_W-1:0] irq_event;
    logic [FLAG_W-1:0] irq_clear;
    logic [FLAG_W-1:0] flags_prev;
    logic irq_pending;

    // An event is a flag going from clear to set, so a held condition raises it once.
    // Software that reads the status register in a loop while a fault persists
    // therefore sees one interrupt, not one per read.
    assign irq_event = flags & ~flags_prev;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_prev <= FLAGS_RESET;
        end else begin
            flags_prev <= flags;
        end
    end

    // Write-one-to-clear lets software drop one source without a read-modify-write
    // that could swallow an event arriving in between.
    assign irq_clear = wr_irq_clear ? reg_wdata[FLAG_W-1:0] : FLAGS_RESET;

    sticky_flags u_irq_flags (
        .core_clk (core_clk),
        .rst (rst),
        .set (irq_event),
        .clear (irq_clear),
        .flags (irq_status)
    );

    // Enable bits only gate the pin; the status bits latch regardless.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_enable <= IRQ_ENABLE_RESET;
        end else if (wr_irq_enable) begin
            irq_enable <= reg_wdata[FLAG_W-1:0];
        end
    end

    // The pin is registered so that it never glitches while status and enable
    // change together; the cost is one cycle of latency.
    assign irq_pending = |(irq_status & irq_enable);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_pending;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] next_rdata;

    // The word is assembled every cycle; only a read strobe lets it reach the pins.
    // Bit 3 is reserved and always reads zero.
    always_comb begin
        status_word = RDATA_RESET;
        status_word[BIT_FAULT_FLAG] = flags[FLAG_FAULT];
        status_word[BIT_RETRY_FLAG] = flags[FLAG_RETRY];
        status_word[BIT_NEG_LIMIT_FLAG] = flags[FLAG_NEG_LIMIT];
        status_word[BIT_ZERO_CROSS_FLAG] = flags[FLAG_ZERO_CROSS];
        status_word[BIT_RESERVED] = RESERVED_VALUE;
        status_word[BIT_SOFTSTART_DONE] = softstart_done;
        status_word[BIT_POWER_GOOD] = power_good;
        status_word[BIT_ENABLED_STATUS] = enabled_status;
    end

    // Anything but a read of a mapped register returns zero.
    always_comb begin
        next_rdata = RDATA_UNMAPPED;
        if (rd_status) begin
            next_rdata = status_word;
        end else if (rd_irq_status) begin
            next_rdata = {{(DATA_W-FLAG_W){1'b0}}, irq_status};
        end else if (rd_irq_enable) begin
            next_rdata = {{(DATA_W-FLAG_W){1'b0}}, irq_enable};
        end
    end

    // Data stand only in the cycle after the strobe, so stale values never linger.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= RDATA_RESET;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : converter_status_register

`default_nettype wire

//--- converter_status_chk.sv
// Port checker for the converter status register, with its bind.
`timescale 1ns/1ps
`default_nettype none
module converter_status_chk
    import converter_status_pkg::*;
(
    input wire logic core_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic [ADDR_W-1:0] reg_addr, // Address.
    input wire logic reg_rd, // Read strobe.
    input wire logic [DATA_W-1:0] reg_rdata, // Read data.
    input wire logic conv_enabled, // Enabled.
    input wire logic ramp_finished, // Ramp done.
    input wire logic power_good_cmp, // Comparator.
    input wire logic oc_terminal_count, // Terminal count.
    input wire logic negative_limit_event, // Negative limit.
    input wire logic zero_cross_event // Zero cross.
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic rd_sts = reg_rd && reg_addr == ADDR_CONVERTER3_STATUS;
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_RESERVED: assert property (rd_sts |=> !reg_rdata[BIT_RESERVED])
        else $error("reserved bit set");
    AST_LIVE: assert property (rd_sts |=> reg_rdata[2:0] == {$past(conv_enabled && ramp_finished),
        $past(power_good_cmp), $past(conv_enabled)}) else $error("live bits wrong");
    AST_ZC_SET: assert property (zero_cross_event ##1 !rd_sts ##1 rd_sts |=> reg_rdata[4])
        else $error("zero cross flag missing");
    AST_NEG_SET: assert property (negative_limit_event ##1 !rd_sts ##1 rd_sts |=> reg_rdata[5])
        else $error("negative limit flag missing");
    AST_RETRY_SET: assert property (oc_terminal_count && !power_good_cmp ##1 !rd_sts ##1 rd_sts
        |=> reg_rdata[7:6] == 2'h3) else $error("retry or fault flag missing");
    AST_FAULT_LIVE: assert property (conv_enabled && ramp_finished && !power_good_cmp ##1 rd_sts
        |=> reg_rdata[BIT_FAULT_FLAG]) else $error("fault flag missing");
    AST_CLEAR: assert property (rd_sts && !zero_cross_event ##1 !zero_cross_event ##1 rd_sts
        |=> !reg_rdata[BIT_ZERO_CROSS_FLAG]) else $error("flag not cleared by read");
endmodule : converter_status_chk
bind converter_status_register converter_status_chk u_chk (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_enabled(conv_enabled),
    .ramp_finished(ramp_finished), .power_good_cmp(power_good_cmp),
    .oc_terminal_count(oc_terminal_count), .negative_limit_event(negative_limit_event),
    .zero_cross_event(zero_cross_event));
`default_nettype wire

//--- tb.sv
// Directed testbench for the converter status register.
`timescale 1ns/1ps
`default_nettype none
module tb import converter_status_pkg::*;;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    logic [2:0] live = 3'h0;
    logic [2:0] ev = 3'h0;
    logic irq;
    int bad_count = 0;
    int n_checks = 0;
    always #10 core_clk = ~core_clk;
    converter_status_register DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_enabled(live[0]), .ramp_finished(live[1]), .power_good_cmp(live[2]),
        .oc_terminal_count(ev[2]), .negative_limit_event(ev[1]), .zero_cross_event(ev[0]),
        .irq(irq));
    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask : wr
    // Data are looked at just after the edge that ends the read cycle, their only valid cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        check(reg_rdata, exp, "reg_rdata");
    endtask : rd
    task automatic pulse(input logic [2:0] e);
        @(posedge core_clk);
        ev <= e;
        @(posedge core_clk);
        ev <= 3'h0;
    endtask : pulse
    task automatic tally_and_finish;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'h0;
        rd(ADDR_CONVERTER3_STATUS, 8'h00);
        rd(8'h55, 8'h00);
        // The fault condition is combination 3; the flag also shows on the next read.
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            live <= i[2:0];
            rd(ADDR_CONVERTER3_STATUS, {i == 3 || i == 4, 4'h0, i[1] & i[0], i[2], i[0]});
        end
        @(posedge core_clk);
        live <= 3'h4;
        pulse(3'h4);
        rd(ADDR_CONVERTER3_STATUS, 8'h02);
        pulse(3'h1);
        rd(ADDR_CONVERTER3_STATUS, 8'h12);
        rd(ADDR_CONVERTER3_STATUS, 8'h02);
        pulse(3'h2);
        rd(ADDR_CONVERTER3_STATUS, 8'h22);
        @(posedge core_clk);
        live <= 3'h0;
        pulse(3'h4);
        rd(ADDR_CONVERTER3_STATUS, 8'hc0);
        rd(ADDR_CONVERTER3_STATUS, 8'h80);
        rd(ADDR_CONVERTER3_STATUS, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h0f);
        check({7'h00, irq}, 8'h00, "irq");
        wr(ADDR_IRQ_ENABLE, 8'h05);
        wr(8'h55, 8'hff);
        wr(ADDR_CONVERTER3_STATUS, 8'hff);
        wr(ADDR_IRQ_STATUS, 8'hff);
        rd(ADDR_IRQ_ENABLE, 8'h05);
        check({7'h00, irq}, 8'h01, "irq");
        wr(ADDR_IRQ_CLEAR, 8'h05);
        rd(ADDR_IRQ_STATUS, 8'h0a);
        check({7'h00, irq}, 8'h00, "irq");
        rd(ADDR_CONVERTER3_STATUS, 8'h00);
        // A pending zero-cross flag and the enables must not survive a reset in mid-run.
        pulse(3'h1);
        @(posedge core_clk);
        rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        rd(ADDR_CONVERTER3_STATUS, 8'h00);
        rd(ADDR_IRQ_ENABLE, 8'h00);
        rd(ADDR_IRQ_STATUS, 8'h00);
        check({7'h00, irq}, 8'h00, "irq");
        tally_and_finish;
    end
endmodule : tb
`default_nettype wire
